// file: hpfm_channel.sv
// one supervised channel: move counter, limit check, jam then service call escalation
`timescale 1ns/10ps
module hpfm_channel #(
  parameter logic [15:0] LEAVE_LIMIT  = 16'd36,
  parameter logic [15:0] ARRIVE_LIMIT = 16'd22
) (
  input  wire logic               clk,
  input  wire logic               reset_n,
  input  wire hpfm_pkg::hpfm_cmd_t cmd,
  input  wire logic               advance,
  input  wire logic               home_position,
  input  wire logic               extra_fault,
  input  wire logic               clear_jam,
  input  wire logic               clear_all,
  output hpfm_pkg::hpfm_flag_t    flags,
  output logic                    fault_pulse
);
  hpfm_pkg::hpfm_move_t move_reg, move_next;
  logic [15:0] cnt_reg, cnt_next;
  logic        seen_reg;
  logic        jam_reg;
  logic        sc_reg;

  wire leaving   = (move_reg == hpfm_pkg::HPFM_LEAVE);
  wire arriving  = (move_reg == hpfm_pkg::HPFM_ARRIVE);
  wire leave_bad = leaving && home_position && (cnt_reg > LEAVE_LIMIT);
  wire arrive_bad = arriving && !home_position && (cnt_reg > ARRIVE_LIMIT);
  wire fault     = leave_bad || arrive_bad || extra_fault;
  wire done      = (leaving && !home_position) || (arriving && home_position) || cmd.stop;

  always_comb begin
    move_next = move_reg;
    cnt_next  = cnt_reg;
    if (cmd.start) begin
      move_next = cmd.toward_home ? hpfm_pkg::HPFM_ARRIVE : hpfm_pkg::HPFM_LEAVE;
      cnt_next  = hpfm_pkg::CNT_RESET;
    end else if (fault || done) begin
      move_next = hpfm_pkg::HPFM_IDLE;
    end else if (advance && move_reg != hpfm_pkg::HPFM_IDLE && cnt_reg != 16'hffff) begin
      cnt_next = cnt_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      move_reg <= hpfm_pkg::HPFM_IDLE;
      cnt_reg  <= hpfm_pkg::CNT_RESET;
      seen_reg <= 1'b0;
      jam_reg  <= 1'b0;
      sc_reg   <= 1'b0;
    end else begin
      move_reg <= move_next;
      cnt_reg  <= cnt_next;
      // new detection wins over a same-cycle clear
      if (fault) begin
        seen_reg <= 1'b1;
        jam_reg  <= !seen_reg || jam_reg;
        sc_reg   <= seen_reg || sc_reg;
      end else begin
        if (clear_jam || clear_all) jam_reg <= 1'b0;
        if (clear_all) begin
          seen_reg <= 1'b0;
          sc_reg   <= 1'b0;
        end
      end
    end
  end

  assign flags       = '{jam: jam_reg, service_call_error: sc_reg};
  assign fault_pulse = fault;
endmodule

// file: hpfm_drive_model.sv
// partner model: stepper drivers and home sensors of gate, side fence and roller lift
`timescale 1ns/10ps
module hpfm_drive_model (
  input  wire logic       clk,
  output logic      [2:0] step_pulse,
  output logic      [2:0] step_home_position
);
  initial begin
    step_pulse         = 3'h0;
    step_home_position = 3'h7;
  end
  // sensor settles before the sequencer starts a move
  task automatic settle(input int i, input bit tw);
    step_home_position[i] = !tw;
    repeat (3) @(negedge clk);
  endtask
  // sensor shows the wrong level until pulse flip; flip 0 models a stuck sensor
  task automatic move(input int i, input bit tw, input int n, input int flip, input int w);
    step_home_position[i] = !tw;
    for (int k = 1; k <= n; k++) begin
      repeat (w) @(negedge clk);
      step_pulse[i] = 1'b1;
      repeat (w) @(negedge clk);
      step_pulse[i] = 1'b0;
      if (k == flip) step_home_position[i] = tw;
    end
  endtask
endmodule

// file: hpfm_monitor.sv
// top: home position fault monitor for gate, fence, lift, punch, paddle and two jogger fences
// What this block does
// - gate leaving home: fault if home still seen after more than 36 pulses
// - gate going home: fault if home not seen after more than 22 pulses
// - first fault of a mechanism raises jam, the second raises service call
// - side fence leaving home: fault if home seen after more than 400 pulses
// - side fence going home: fault if home unseen after more than 600 pulses
// - roller lift leaving home: fault if home seen after more than 36 pulses
// - roller lift going home: fault if home unseen after more than 22 pulses
// - punch unit absent during initialization is a punch fault
// - no punch rotation 30 ms after motor on from home is a fault
// - no punch encoder pulse 5 ms after motor on from home is a fault
// - punch home not seen 400 ms after motor on is a fault
// - paddle and jogger fences: home still seen over 400 ms after leaving starts
// - paddle and jogger fences: home unseen 400 ms after going home starts
`timescale 1ns/10ps
module hpfm_monitor #(
  parameter int unsigned MS_CYCLES = hpfm_pkg::MS_TICK_CYCLES
) (
  input  wire logic                                  clk,
  input  wire logic                                  reset_n,
  input  wire hpfm_pkg::hpfm_cmd_t [2:0]             step_cmd,
  input  wire logic [2:0]                            step_pulse,
  input  wire logic [2:0]                            step_home_position,
  input  wire hpfm_pkg::hpfm_cmd_t [2:0]             timed_cmd,
  input  wire logic [2:0]                            timed_home_position,
  input  wire logic                                  punch_motor_on,
  input  wire logic                                  punch_init,
  input  wire logic                                  punch_present,
  input  wire logic                                  punch_rotation,
  input  wire logic                                  punch_encoder,
  input  wire logic                                  punch_home_position,
  input  wire logic                                  clear_jam,
  input  wire logic                                  clear_all,
  output hpfm_pkg::hpfm_flag_t [6:0]                 mech_flags,
  output logic                                       jam_any,
  output logic                                       service_call_error_any
);
  // channels: 0 junction_gate, 1 side fence, 2 roller lift, 3 punch, 4 paddle, 5 fence 1, 6 fence 2
  localparam logic [15:0] LEAVE_TBL [3]  = '{hpfm_pkg::GATE_LEAVE_PULSES,
                                             hpfm_pkg::FENCE_LEAVE_PULSES,
                                             hpfm_pkg::LIFT_LEAVE_PULSES};
  localparam logic [15:0] ARRIVE_TBL [3] = '{hpfm_pkg::GATE_ARRIVE_PULSES,
                                             hpfm_pkg::FENCE_ARRIVE_PULSES,
                                             hpfm_pkg::LIFT_ARRIVE_PULSES};

  // pins from motors and sensors pass two flops before any logic
  localparam int unsigned PIN_W = 15;
  logic [PIN_W-1:0] pin_meta_reg, pin_sync_reg;
  logic [2:0]       pulse_last_reg;
  logic             rot_last_reg, enc_last_reg;
  wire [PIN_W-1:0]  pin_raw = {step_pulse,
                               step_home_position,
                               timed_home_position,
                               punch_present,
                               punch_rotation,
                               punch_encoder,
                               punch_home_position,
                               punch_motor_on,
                               punch_init};
  wire [2:0] pulse_s   = pin_sync_reg[14:12];
  wire [2:0] step_hp_s = pin_sync_reg[11:9];
  wire [2:0] timed_hp_s = pin_sync_reg[8:6];
  wire present_s = pin_sync_reg[5];
  wire rot_s     = pin_sync_reg[4];
  wire enc_s     = pin_sync_reg[3];
  wire punch_hp_s = pin_sync_reg[2];
  wire motor_on_s = pin_sync_reg[1];
  wire init_s    = pin_sync_reg[0];
  // rising edges only; history resets low, the idle level of these pins
  wire [2:0] pulse_edge = pulse_s & ~pulse_last_reg;
  wire rot_edge  = rot_s & ~rot_last_reg;
  wire enc_edge  = enc_s & ~enc_last_reg;

  // millisecond tick shared by timed channels and punch
  logic [31:0] tick_cnt_reg;
  // free running, so a move may see its first tick up to one ms early
  wire         ms_tick = (tick_cnt_reg == MS_CYCLES - 1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_reg   <= '0;
      pin_sync_reg   <= '0;
      pulse_last_reg <= 3'h0;
      rot_last_reg   <= 1'b0;
      enc_last_reg   <= 1'b0;
      tick_cnt_reg   <= 32'h0;
    end else begin
      pin_meta_reg   <= pin_raw;
      pin_sync_reg   <= pin_meta_reg;
      pulse_last_reg <= pulse_s;
      rot_last_reg   <= rot_s;
      enc_last_reg   <= enc_s;
      tick_cnt_reg   <= ms_tick ? 32'h0 : tick_cnt_reg + 32'h1;
    end
  end

  logic [6:0] fault_pulse;

  genvar g;
  generate
    // stepper mechanisms count drive pulse edges
    for (g = 0; g < 3; g++) begin : g_step
      hpfm_channel #(
        .LEAVE_LIMIT  (LEAVE_TBL[g]),
        .ARRIVE_LIMIT (ARRIVE_TBL[g])
      ) u_step (
        .clk           (clk),
        .reset_n       (reset_n),
        .cmd           (step_cmd[g]),
        .advance       (pulse_edge[g]),
        .home_position (step_hp_s[g]),
        .extra_fault   (1'b0),
        .clear_jam     (clear_jam),
        .clear_all     (clear_all),
        .flags         (mech_flags[g]),
        .fault_pulse   (fault_pulse[g])
      );
    end
    // dc mechanisms count millisecond ticks against one shared limit
    for (g = 0; g < 3; g++) begin : g_timed
      hpfm_channel #(
        .LEAVE_LIMIT  (hpfm_pkg::TIMED_LIMIT_MS),
        .ARRIVE_LIMIT (hpfm_pkg::TIMED_LIMIT_MS)
      ) u_timed (
        .clk           (clk),
        .reset_n       (reset_n),
        .cmd           (timed_cmd[g]),
        .advance       (ms_tick),
        .home_position (timed_hp_s[g]),
        .extra_fault   (1'b0),
        .clear_jam     (clear_jam),
        .clear_all     (clear_all),
        .flags         (mech_flags[g+4]),
        .fault_pulse   (fault_pulse[g+4])
      );
    end
  endgenerate

  // punch run supervision; motor on edge starts a run, motor off ends it
  logic        motor_last_reg;
  logic        run_reg;
  // rotation and encoder limits apply only to a run started at home
  logic        from_home_reg;
  logic        rot_seen_reg, enc_seen_reg;
  logic [15:0] punch_ms_reg;
  logic        absent_reg;
  wire motor_rise = motor_on_s & ~motor_last_reg;
  // free tick: strict compares keep a punch fault from landing before its time
  wire punch_rot_bad  = run_reg && from_home_reg && !rot_seen_reg && (punch_ms_reg > hpfm_pkg::PUNCH_ROT_MS);
  wire punch_enc_bad  = run_reg && from_home_reg && !enc_seen_reg && (punch_ms_reg > hpfm_pkg::PUNCH_ENC_MS);
  wire punch_home_bad = run_reg && !punch_hp_s && (punch_ms_reg > hpfm_pkg::PUNCH_HOME_MS);
  wire absent_bad     = init_s && !present_s && !absent_reg;
  wire punch_fault_p  = punch_rot_bad | punch_enc_bad | punch_home_bad | absent_bad;
  wire run_end    = run_reg & (~motor_on_s | punch_fault_p);
  // home reached only counts once the cam has left home, else it would pass at motor on
  logic left_home_reg;
  wire  home_done = run_reg && left_home_reg && punch_hp_s;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      motor_last_reg <= 1'b0;
      run_reg        <= 1'b0;
      from_home_reg  <= 1'b0;
      rot_seen_reg   <= 1'b0;
      enc_seen_reg   <= 1'b0;
      left_home_reg  <= 1'b0;
      punch_ms_reg   <= hpfm_pkg::CNT_RESET;
      absent_reg     <= 1'b0;
    end else begin
      motor_last_reg <= motor_on_s;
      // absence reported once per init window, not on every cycle of it
      absent_reg     <= init_s && !present_s; // one report per init window
      if (motor_rise) begin
        run_reg       <= 1'b1;
        from_home_reg <= punch_hp_s;
        rot_seen_reg  <= 1'b0;
        enc_seen_reg  <= 1'b0;
        left_home_reg <= !punch_hp_s;
        punch_ms_reg  <= hpfm_pkg::CNT_RESET;
      // a fault, motor off or home reached closes the run
      end else if (run_end || home_done) begin
        run_reg <= 1'b0;
      end else if (run_reg) begin
        if (rot_edge) rot_seen_reg <= 1'b1;
        if (enc_edge) enc_seen_reg <= 1'b1;
        if (!punch_hp_s) left_home_reg <= 1'b1;
        if (ms_tick && punch_ms_reg != 16'hffff) begin
          punch_ms_reg <= punch_ms_reg + 16'h0001;
        end
      end
    end
  end

  // punch escalation reuses a channel with no move of its own
  hpfm_channel #(
    .LEAVE_LIMIT  (hpfm_pkg::PUNCH_HOME_MS),
    .ARRIVE_LIMIT (hpfm_pkg::PUNCH_HOME_MS)
  ) u_punch (
    .clk           (clk),
    .reset_n       (reset_n),
    .cmd           ('0),
    .advance       (1'b0),
    .home_position (punch_hp_s),
    .extra_fault   (punch_fault_p),
    .clear_jam     (clear_jam),
    .clear_all     (clear_all),
    .flags         (mech_flags[3]),
    .fault_pulse   (fault_pulse[3])
  );

  always_comb begin
    jam_any                = 1'b0;
    service_call_error_any = 1'b0;
    for (int i = 0; i < 7; i++) begin
      jam_any                = jam_any | mech_flags[i].jam;
      service_call_error_any = service_call_error_any | mech_flags[i].service_call_error;
    end
  end
endmodule

// file: hpfm_monitor_bench.sv
// testbench: home position fault monitor against a flag model
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module hpfm_monitor_bench;
  localparam int MS = 10;
  logic clk, reset_n, clear_jam, clear_all, p_on, p_init, p_pres, p_rot, p_enc, p_home;
  hpfm_pkg::hpfm_cmd_t [2:0] step_cmd, timed_cmd;
  logic [2:0] step_pulse, step_home_position, timed_home_position;
  hpfm_pkg::hpfm_flag_t [6:0] mech_flags;
  logic jam_any, service_call_error_any;
  bit ej [7], es [7], seen [7];
  bit [31:0] rng = 49;
  int n_errors = 0, n_checks = 0, cyc = 0;
  hpfm_monitor #(.MS_CYCLES(MS)) dut_u (.clk(clk), .reset_n(reset_n), .step_cmd(step_cmd),
    .step_pulse(step_pulse), .step_home_position(step_home_position), .timed_cmd(timed_cmd),
    .timed_home_position(timed_home_position), .punch_motor_on(p_on), .punch_init(p_init),
    .punch_present(p_pres), .punch_rotation(p_rot), .punch_encoder(p_enc), .punch_home_position(p_home),
    .clear_jam(clear_jam), .clear_all(clear_all), .mech_flags(mech_flags), .jam_any(jam_any),
    .service_call_error_any(service_call_error_any));
  hpfm_drive_model drv_u (.clk(clk), .step_pulse(step_pulse), .step_home_position(step_home_position));
  function bit [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function int lim(int i, bit tw);
    if (i == 1) return tw ? int'(hpfm_pkg::FENCE_ARRIVE_PULSES) : int'(hpfm_pkg::FENCE_LEAVE_PULSES);
    if (i == 2) return tw ? int'(hpfm_pkg::LIFT_ARRIVE_PULSES) : int'(hpfm_pkg::LIFT_LEAVE_PULSES);
    return tw ? int'(hpfm_pkg::GATE_ARRIVE_PULSES) : int'(hpfm_pkg::GATE_LEAVE_PULSES);
  endfunction
  // first fault of a mechanism is a jam, any later one a service call
  function void fault(int i);
    if (seen[i]) es[i] = 1;
    else ej[i] = 1;
    seen[i] = 1;
  endfunction
  task check_flags();
    logic aj, ae;
    aj = 0;
    ae = 0;
    for (int i = 0; i < 7; i++) begin
      `CHK("mech_flags", {ej[i], es[i]}, mech_flags[i])
      aj |= ej[i];
      ae |= es[i];
    end
    `CHK("jam_any", aj, jam_any)
    `CHK("service_call_error_any", ae, service_call_error_any)
  endtask
  task issue(bit tmd, int i, bit tw, bit stp);
    @(negedge clk);
    if (tmd) timed_cmd[i] = '{start: !stp, toward_home: tw, stop: stp};
    else step_cmd[i] = '{start: !stp, toward_home: tw, stop: stp};
    @(negedge clk);
    timed_cmd = '0;
    step_cmd = '0;
  endtask
  task step_move(int i, bit tw, int n, int flip);
    drv_u.settle(i, tw);
    issue(0, i, tw, 0);
    drv_u.move(i, tw, n, flip, 2 + int'(rnd() % 3));
    repeat (8) @(negedge clk);
    if ((flip == 0 || flip > lim(i, tw)) && n > lim(i, tw)) fault(i);
    check_flags();
    issue(0, i, tw, 1);
  endtask
  task clear(bit all);
    @(negedge clk);
    if (all) clear_all = 1;
    else clear_jam = 1;
    @(negedge clk);
    {clear_all, clear_jam} = 2'h0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 7; i++) begin
      ej[i] = 0;
      if (all) {es[i], seen[i]} = 2'h0;
    end
    check_flags();
  endtask
  task wrap_up();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  // whole run needs about 40k cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      n_errors++;
      wrap_up();
    end
  end
  initial begin
    {reset_n, clear_jam, clear_all, p_on, p_init, p_rot, p_enc} = 7'h00;
    {p_pres, p_home} = 2'h3;
    step_cmd = '0;
    timed_cmd = '0;
    timed_home_position = 3'h7;
    repeat (3) @(negedge clk);
    reset_n = 1;
    check_flags();
    for (int i = 0; i < 3; i++) begin
      step_move(i, 0, lim(i, 0), 0);
      step_move(i, 0, lim(i, 0) + 1, 0);
      step_move(i, 1, lim(i, 1), 0);
      step_move(i, 1, lim(i, 1) + 1, 0);
      step_move(i, 1, lim(i, 1) + 3, 3);
    end
    clear(0);
    clear(1);
    for (int k = 0; k < 4; k++) begin
      timed_home_position[k % 3] = k < 3;
      issue(1, k % 3, k >= 3, 0);
      repeat (398 * MS) @(negedge clk);
      check_flags();
      repeat (12 * MS) @(negedge clk);
      fault(4 + k % 3);
      check_flags();
      issue(1, k % 3, k >= 3, 1);
    end
    clear(1);
    p_on = 1;
    repeat (2 * MS) @(negedge clk);
    {p_rot, p_home} = 2'h2;
    repeat (2 * MS) @(negedge clk);
    check_flags();
    repeat (4 * MS) @(negedge clk);
    fault(3);
    check_flags();
    repeat (12 * MS) @(negedge clk);
    p_home = 1;
    repeat (20 * MS) @(negedge clk);
    p_on = 0;
    check_flags();
    {p_init, p_pres} = 2'h2;
    repeat (10) @(negedge clk);
    fault(3);
    check_flags();
    {p_init, p_pres, p_rot, p_enc, p_on, p_home} = 6'h11;
    clear(1);
    p_on = 1;
    repeat (2 * MS) @(negedge clk);
    p_enc = 1;
    repeat (27 * MS) @(negedge clk);
    check_flags();
    repeat (4 * MS) @(negedge clk);
    fault(3);
    check_flags();
    {p_on, p_enc} = 2'h0;
    repeat (5) @(negedge clk);
    p_on = 1;
    repeat (MS) @(negedge clk);
    {p_rot, p_enc, p_home} = 3'h6;
    repeat (397 * MS) @(negedge clk);
    check_flags();
    repeat (6 * MS) @(negedge clk);
    fault(3);
    check_flags();
    wrap_up();
  end
endmodule

// file: hpfm_monitor_sva.sv
// checker: flag escalation and minimum fault latency of the home position fault monitor
`timescale 1ns/10ps
module hpfm_monitor_chk #(
  parameter int unsigned MS_CYCLES = 40000
) (
  input wire logic                      clk,
  input wire logic                      reset_n,
  input wire hpfm_pkg::hpfm_cmd_t [2:0] step_cmd,
  input wire logic [2:0]                step_pulse,
  input wire hpfm_pkg::hpfm_cmd_t [2:0] timed_cmd,
  input wire logic                      punch_motor_on,
  input wire logic                      punch_init,
  input wire logic                      clear_jam,
  input wire logic                      clear_all,
  input wire hpfm_pkg::hpfm_flag_t [6:0] mech_flags,
  input wire logic                      jam_any,
  input wire logic                      service_call_error_any
);
  localparam int T_MIN = 400 * MS_CYCLES;
  logic [6:0] fl, jm, sc, seen;
  logic [2:0] pin_q;
  logic       motor_q, init_seen;
  int         pcnt [3];
  int         tcyc [3];
  int         pcyc;
  always_comb for (int i = 0; i < 7; i++) begin
    jm[i] = mech_flags[i].jam;
    sc[i] = mech_flags[i].service_call_error;
    fl[i] = jm[i] | sc[i];
  end
  // raw pin counts run ahead of the synchronised ones, so lower bounds stay safe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_q     <= 3'h0;
      motor_q   <= 1'b0;
      init_seen <= 1'b0;
      seen      <= 7'h00;
      pcyc      <= 0;
      for (int i = 0; i < 3; i++) begin
        pcnt[i] <= 0;
        tcyc[i] <= 0;
      end
    end else begin
      pin_q     <= step_pulse;
      motor_q   <= punch_motor_on;
      init_seen <= init_seen | punch_init;
      seen      <= clear_all ? 7'h00 : (seen | jm);
      pcyc      <= (punch_motor_on && !motor_q) ? 0 : pcyc + 1;
      for (int i = 0; i < 3; i++) begin
        pcnt[i] <= step_cmd[i].start ? 0 : pcnt[i] + int'(step_pulse[i] && !pin_q[i]);
        tcyc[i] <= timed_cmd[i].start ? 0 : tcyc[i] + 1;
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_jam_drop;
    $fell(jam_any);
  endsequence
  sequence s_was_cleared;
    $past(clear_jam || clear_all);
  endsequence
  chk_jam_any_or: assert property (jam_any == (|jm))
    else $error("jam_any differs from mechanism jams");
  chk_sc_any_or: assert property (service_call_error_any == (|sc))
    else $error("service call summary differs from mechanisms");
  chk_jam_stands: assert property (s_jam_drop |-> s_was_cleared)
    else $error("jam dropped without a clear");
  chk_sc_stands: assert property ($fell(service_call_error_any) |-> $past(clear_all))
    else $error("service call dropped without clear_all");
  for (genvar g = 0; g < 7; g++) begin : g_esc
    chk_sc_after_jam: assert property ($rose(sc[g]) |-> seen[g] && !$rose(jm[g]))
      else $error("service call without an earlier jam");
  end
  chk_gate_pulse_min: assert property ($rose(fl[0]) |-> pcnt[0] >= 23)
    else $error("gate fault before its pulse limit");
  chk_fence_pulse_min: assert property ($rose(fl[1]) |-> pcnt[1] >= 401)
    else $error("side fence fault before its pulse limit");
  chk_lift_pulse_min: assert property ($rose(fl[2]) |-> pcnt[2] >= 23)
    else $error("roller lift fault before its pulse limit");
  for (genvar g = 0; g < 3; g++) begin : g_tmd
    chk_timed_ms_min: assert property ($rose(fl[4+g]) |-> tcyc[g] >= T_MIN)
      else $error("timed mechanism fault before 400 ms");
  end
  chk_punch_ms_min: assert property ($rose(fl[3]) |-> init_seen || pcyc >= 5 * MS_CYCLES)
    else $error("punch fault too early");
endmodule
bind hpfm_monitor hpfm_monitor_chk #(.MS_CYCLES(MS_CYCLES)) chk_u (.clk(clk), .reset_n(reset_n),
  .step_cmd(step_cmd), .step_pulse(step_pulse), .timed_cmd(timed_cmd), .punch_motor_on(punch_motor_on),
  .punch_init(punch_init), .clear_jam(clear_jam), .clear_all(clear_all), .mech_flags(mech_flags),
  .jam_any(jam_any), .service_call_error_any(service_call_error_any));

// file: hpfm_pkg.sv
// package: limits, timing constants and carrier types for the home position fault monitor
package hpfm_pkg;
  localparam int unsigned CLK_HZ           = 40_000_000;
  localparam int unsigned MS_TICK_CYCLES   = CLK_HZ / 1000;
  localparam int unsigned CNT_W            = 16;
  localparam int unsigned N_STEP           = 3;
  localparam int unsigned N_TIMED          = 3;
  localparam int unsigned N_MECH           = 7;
  localparam logic [15:0] GATE_LEAVE_PULSES  = 16'd36;
  localparam logic [15:0] GATE_ARRIVE_PULSES = 16'd22;
  localparam logic [15:0] FENCE_LEAVE_PULSES = 16'd400;
  localparam logic [15:0] FENCE_ARRIVE_PULSES = 16'd600;
  localparam logic [15:0] LIFT_LEAVE_PULSES  = 16'd36;
  localparam logic [15:0] LIFT_ARRIVE_PULSES = 16'd22;
  localparam logic [15:0] TIMED_LIMIT_MS     = 16'd400;
  localparam logic [15:0] PUNCH_ROT_MS       = 16'd30;
  localparam logic [15:0] PUNCH_ENC_MS       = 16'd5;
  localparam logic [15:0] PUNCH_HOME_MS      = 16'd400;
  localparam logic [15:0] CNT_RESET          = 16'h0000;
  localparam logic [1:0]  LEVEL_NONE         = 2'h0;

  typedef enum logic [1:0] {
    HPFM_IDLE   = 2'b00,
    HPFM_LEAVE  = 2'b01,
    HPFM_ARRIVE = 2'b10
  } hpfm_move_t;

  // one move request from the sequencer: start pulse, direction and stop
  typedef struct packed {
    logic start;
    logic toward_home;
    logic stop;
  } hpfm_cmd_t;

  // fault report per mechanism
  typedef struct packed {
    logic jam;
    logic service_call_error;
  } hpfm_flag_t;
endpackage
